// File: bench/data_eeprom_access_controller_test.sv
`timescale 1ns/1ps
`include "deac_regs.svh"
module data_eeprom_access_controller_test;
    import deac_pkg::*;
    localparam int PCYC = 16;
    localparam logic [7:0] CT = `DEAC_CTRL_IDX;
    localparam logic [7:0] BK = `DEAC_BANK_IDX;
    localparam logic [7:0] RA [8] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1f, 8'h08};
    localparam logic [7:0] RE [8] = '{8'h22, 8'hff, 8'h11, 8'h33, 8'h55, 8'hff, 8'hff, 8'hff};
    logic clk;
    logic rst_n;
    logic [9:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int miscompares = 0;
    int n_checks = 0;
    int cyc = 0;

    // ****
    // Clock, cycle count, design and core model
    // ****
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end
    deac_top #(.PROG_CYCLES(PCYC)) DUT (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    deac_cpu cpu (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

    // ****
    // Shared checks
    // ****
    task automatic chk(input string nm, input deac_byte_t exp, input deac_byte_t got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Read one location and compare
    task automatic rc(input string nm, input logic [7:0] idx, input deac_byte_t exp);
        deac_byte_t d;
        cpu.rd(idx, d);
        chk(nm, exp, d);
    endtask
    // Poll busy until clear, then judge the span since the starting write
    task automatic wait_idle(input int t0);
        deac_byte_t d;
        d = 8'h02;
        while (d[`DEAC_BIT_BUSY] !== 1'b0) begin
            cpu.rd(CT, d);
        end
        chk("busy span", 8'h01, 8'((cyc - t0 >= PCYC + 1) && (cyc - t0 <= PCYC + 6)));
    endtask
    // Verdict and end of run
    task automatic summarize;
        if (miscompares == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ****
    // Scenarios
    // ****
    // Reset values, page selection, window edges, unmapped place
    task automatic t_reset;
        rc("ctrl reset", CT, `DEAC_CTRL_RESET);
        rc("no page", 8'h00, `DEAC_NO_DATA);
        cpu.wr(BK, 8'h03);
        rc("two pages", 8'h00, `DEAC_NO_DATA);
        cpu.wr(BK, `DEAC_PAGE0_SEL);
        rc("virgin lo", 8'h00, `DEAC_VIRGIN);
        rc("virgin hi", `DEAC_WIN_LAST, `DEAC_VIRGIN);
        // A write with its low lane off must not reach the control bits
        cpu.be = 4'h0;
        cpu.wr(CT, 8'h40);
        cpu.be = 4'h1;
        rc("lane off", 8'h01, `DEAC_VIRGIN);
        rc("bank wo", BK, 8'h00);
        cpu.wr(8'h40, 8'h5a);
        rc("unmapped", 8'h40, 8'h00);
    endtask
    // Byte mode with control write and array access attempted while busy
    task automatic t_byte;
        int t0;
        cpu.wr(CT, 8'h01);
        cpu.wr(8'h05, 8'ha5);
        t0 = cyc;
        rc("busy on", CT, 8'h02);
        cpu.wr(CT, 8'h40);
        cpu.wr(8'h06, 8'h11);
        rc("busy read", 8'h06, `DEAC_NO_DATA);
        wait_idle(t0);
        rc("byte", 8'h05, 8'ha5);
        rc("neighbour", 8'h06, `DEAC_VIRGIN);
        rc("below", 8'h04, `DEAC_VIRGIN);
    endtask
    // Writes without enable and refused start bits
    task automatic t_refused;
        cpu.wr(CT, 8'h00);
        cpu.wr(8'h05, 8'h33);
        rc("no enable", CT, 8'h00);
        cpu.wr(CT, 8'h09);
        rc("start no row", CT, 8'h00);
        cpu.wr(CT, 8'h04);
        cpu.wr(CT, 8'h0c);
        rc("start no ena", CT, 8'h00);
        cpu.wr(CT, 8'h00);
        rc("kept", 8'h05, 8'ha5);
    endtask
    // Standby voids accesses; slow master meanwhile
    task automatic t_standby;
        cpu.gap = 2;
        cpu.wr(CT, 8'h41);
        rc("stby read", 8'h05, `DEAC_NO_DATA);
        cpu.wr(8'h07, 8'h3c);
        rc("stby busy", CT, 8'h00);
        cpu.wr(CT, 8'h00);
        rc("awake", 8'h07, `DEAC_VIRGIN);
        cpu.gap = 0;
    endtask
    // Row mode on page 1: abandoned load, then a partial row
    task automatic t_row;
        int t0;
        cpu.wr(BK, `DEAC_PAGE1_SEL);
        cpu.wr(CT, 8'h05);
        cpu.wr(8'h19, 8'h77);
        cpu.wr(CT, 8'h01);
        rc("dropped", 8'h19, `DEAC_VIRGIN);
        cpu.wr(CT, 8'h05);
        cpu.wr(8'h1a, 8'h11);
        cpu.wr(8'h18, 8'h22);
        cpu.wr(8'h1b, 8'h33);
        cpu.wr(CT, 8'h0d);
        t0 = cyc;
        wait_idle(t0);
        cpu.wr(8'h1c, 8'h55);
        t0 = cyc;
        rc("row mode off", CT, 8'h02);
        wait_idle(t0);
        for (int i = 0; i < 8; i++) begin
            rc("row byte", RA[i], RE[i]);
        end
        cpu.wr(BK, `DEAC_PAGE0_SEL);
        rc("page0 row", 8'h18, `DEAC_VIRGIN);
    endtask

    // Reset, then every scenario in turn
    initial begin
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_byte;
        t_refused;
        t_standby;
        t_row;
        summarize;
    end
    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        summarize;
    end
endmodule

// File: bench/deac_cpu.sv
`timescale 1ns/1ps
`include "deac_regs.svh"
// ****
// Core-side master for data-space accesses
// ****
module deac_cpu (
    input wire logic clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [9:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    logic [7:0] ctrl_image;
    int gap = 0;
    // Lane enables sent with the next write
    logic [3:0] be = 4'h1;
    // Bus idle from time zero
    initial begin
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h1;
        ctrl_image = 8'h00;
    end
    // Byte write; image first, control bits 5 and 4 sent as zero
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] w;
        w = (idx == `DEAC_CTRL_IDX) ? (d & 8'hcf) : d;
        if (idx == `DEAC_CTRL_IDX) begin
            ctrl_image = w;
        end
        repeat (gap + 1) @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, w};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    // Byte read, data taken at the edge that sees waitrequest low
    task automatic rd(input logic [7:0] idx, output logic [7:0] d);
        repeat (gap + 1) @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata[7:0];
        avs_read <= 1'b0;
    endtask
endmodule

// File: rtl/deac_array.sv
`timescale 1ns/1ps
`include "deac_regs.svh"
module deac_array (
    input wire logic clk,
    input wire logic rst_n,
    deac_nv_if.arr nv
);
    import deac_pkg::*;
    typedef struct packed {
        logic [127:0][7:0] mem;
    } deac_arr_t;
    deac_arr_t st_reg, st_next;

    // Commit written row bytes when the programming cycle ends
    always_comb begin
        st_next = st_reg;
        if (nv.tm_done) begin
            for (int i = 0; i < 8; i++) begin
                if (nv.wr_mask[i]) begin
                    st_next.mem[{nv.wr_page, nv.wr_row, 3'(i)}] = nv.wr_data[i];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= {128{`DEAC_VIRGIN}};
        end else begin
            st_reg <= st_next;
        end
    end

    // Read port idles at zero when the array is disabled
    assign nv.rd_data = nv.rd_en ? st_reg.mem[{nv.rd_page, nv.rd_addr}] : `DEAC_NO_DATA;
endmodule

// File: rtl/deac_nv_if.sv
`timescale 1ns/1ps
interface deac_nv_if;
    import deac_pkg::*;
    logic rd_en;
    logic rd_page;
    logic [5:0] rd_addr;
    deac_byte_t rd_data;
    logic wr_page;
    logic [2:0] wr_row;
    logic [7:0] wr_mask;
    deac_row_t wr_data;
    logic tm_start;
    logic tm_busy;
    logic tm_done;
    modport ctl(output rd_en, rd_page, rd_addr, wr_page, wr_row, wr_mask, wr_data, tm_start,
                input rd_data, tm_busy, tm_done);
    modport arr(input rd_en, rd_page, rd_addr, wr_page, wr_row, wr_mask, wr_data, tm_done,
                output rd_data);
    modport tmr(input tm_start, output tm_busy, tm_done);
endinterface

// File: rtl/deac_pkg.sv
package deac_pkg;
    typedef logic [7:0] deac_byte_t;
    typedef logic [7:0][7:0] deac_row_t;
    typedef enum logic [1:0] {PGM_IDLE, PGM_BYTE, PGM_ROW} deac_pgm_t;
endpackage

// File: rtl/deac_regs.svh
`ifndef DEAC_REGS_SVH
`define DEAC_REGS_SVH
`define DEAC_CTRL_IDX 8'hdf
`define DEAC_BANK_IDX 8'hcb
`define DEAC_WIN_LAST 8'h3f
`define DEAC_CTRL_RESET 8'h00
`define DEAC_BANK_RESET 8'h00
`define DEAC_PAGE0_SEL 8'h01
`define DEAC_PAGE1_SEL 8'h02
`define DEAC_BIT_STANDBY 6
`define DEAC_BIT_START 3
`define DEAC_BIT_ROWMODE 2
`define DEAC_BIT_BUSY 1
`define DEAC_BIT_ENABLE 0
`define DEAC_VIRGIN 8'hff
`define DEAC_NO_DATA 8'h00
`define DEAC_PROG_CYCLES 200
`endif

// File: rtl/deac_timer.sv
`timescale 1ns/1ps
`include "deac_regs.svh"
module deac_timer #(
    parameter int unsigned PROG_CYCLES = `DEAC_PROG_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    deac_nv_if.tmr nv
);
    import deac_pkg::*;
    typedef struct packed {
        logic busy;
        logic done;
        logic [15:0] cnt;
        logic [15:0] run;
    } deac_tmr_t;
    deac_tmr_t st_reg, st_next;

    // Count one programming cycle, busy for exactly PROG_CYCLES clocks
    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (st_reg.busy) begin
            st_next.run = st_reg.run + 16'h0001;
            if (st_reg.cnt == 16'h0000) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt - 16'h0001;
            end
        end else if (nv.tm_start) begin
            st_next.busy = 1'b1;
            st_next.cnt = 16'(PROG_CYCLES - 1);
            st_next.run = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign nv.tm_busy = st_reg.busy;
    assign nv.tm_done = st_reg.done;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_busy_length: assert property ($fell(st_reg.busy) |-> st_reg.run == 16'(PROG_CYCLES))
        else $error("busy length differs from programming cycle count");
    a_busy_rises: assert property (nv.tm_start && !st_reg.busy |=> st_reg.busy)
        else $error("busy did not rise after start");
endmodule

// File: rtl/deac_top.sv
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "deac_regs.svh"
module deac_top #(
    parameter int unsigned PROG_CYCLES = `DEAC_PROG_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import deac_pkg::*;

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic wait_req;
        deac_byte_t rdata;
        logic standby;
        logic enable;
        logic row_mode;
        logic row_start;
        deac_byte_t bank;
        logic row_held;
        logic row_page;
        logic [2:0] row_idx;
        deac_row_t latch;
        logic [7:0] mask;
        deac_pgm_t pgm;
        logic tm_start;
    } deac_state_t;

    deac_state_t st_reg, st_next;
    deac_nv_if nv();

    // ********************************************************
    // Decode helpers
    // ********************************************************

    // Window hit for data addresses 00h..3Fh
    function automatic logic win_hit(input logic [7:0] idx);
        win_hit = (idx <= `DEAC_WIN_LAST);
    endfunction

    // Page selected by the bank byte; only codes 01h and 02h are valid
    function automatic logic page_valid(input deac_byte_t bank);
        page_valid = (bank == `DEAC_PAGE0_SEL) || (bank == `DEAC_PAGE1_SEL);
    endfunction

    function automatic logic page_num(input deac_byte_t bank);
        page_num = (bank == `DEAC_PAGE1_SEL);
    endfunction

    logic [7:0] idx;
    logic accept;
    logic wr_ok;
    logic busy_now;
    logic access_ok;
    logic hit_ctrl;
    logic hit_bank;
    logic hit_win;
    deac_byte_t wdata;
    logic row_mode_now;

    // Bus request decode, register index is the byte address over four
    assign idx = avs_address[9:2];
    assign accept = (avs_read || avs_write) && st_reg.wait_req;
    assign wr_ok = accept && avs_write && avs_byteenable[0];
    assign wdata = avs_writedata[7:0];
    assign hit_ctrl = (idx == `DEAC_CTRL_IDX);
    assign hit_bank = (idx == `DEAC_BANK_IDX);
    assign hit_win = win_hit(idx);

    // Busy covers the start pulse cycle as well as the timer run
    assign busy_now = nv.tm_busy || st_reg.tm_start;

    // Array is reachable only with a page, awake and idle
    assign access_ok = page_valid(st_reg.bank) && !st_reg.standby && !busy_now;

    // Row mode as a control write sees it; a finishing row cycle has already dropped it
    assign row_mode_now = st_reg.row_mode && !(nv.tm_done && st_reg.pgm == PGM_ROW);

    // ********************************************************
    // Array and timer connections
    // ********************************************************

    // Read address is the low six index bits, taken whole
    assign nv.rd_en = access_ok && !st_reg.row_mode;
    assign nv.rd_page = page_num(st_reg.bank);
    assign nv.rd_addr = idx[5:0];
    assign nv.wr_page = st_reg.row_page;
    assign nv.wr_row = st_reg.row_idx;
    assign nv.wr_mask = st_reg.mask;
    assign nv.wr_data = st_reg.latch;
    assign nv.tm_start = st_reg.tm_start;

    deac_timer #(
        .PROG_CYCLES(PROG_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .nv(nv.tmr)
    );

    deac_array u_array (
        .clk(clk),
        .rst_n(rst_n),
        .nv(nv.arr)
    );

    // ********************************************************
    // Next state
    // ********************************************************
    always_comb begin
        st_next = st_reg;
        st_next.tm_start = 1'b0;
        st_next.wait_req = 1'b1;

        // End of a programming cycle releases the row, and after a row cycle the mode bits
        if (nv.tm_done) begin
            st_next.mask = 8'h00;
            st_next.row_held = 1'b0;
            st_next.pgm = PGM_IDLE;
            case (st_reg.pgm)
                PGM_ROW: begin
                    // A finished row cycle leaves parallel mode entirely
                    st_next.row_start = 1'b0;
                    st_next.row_mode = 1'b0;
                end
                PGM_BYTE: begin
                    // A byte cycle keeps the mode bits that software last wrote
                    st_next.row_start = 1'b0;
                end
                default: begin
                    st_next.row_start = 1'b0;
                end
            endcase
        end

        // One answer per request; the cycle after it refuses a re-accept
        if (accept) begin
            st_next.wait_req = 1'b0;
            st_next.rdata = `DEAC_NO_DATA;
            if (avs_read) begin
                if (hit_ctrl) begin
                    // Only busy is readable, the other bits are write only
                    st_next.rdata[`DEAC_BIT_BUSY] = busy_now;
                end else if (hit_win && nv.rd_en) begin
                    st_next.rdata = nv.rd_data;
                end
            end
        end

        // Bank register write
        if (wr_ok && hit_bank) begin
            st_next.bank = wdata;
        end

        // Control register write, frozen during programming
        if (wr_ok && hit_ctrl && !busy_now) begin
            st_next.standby = wdata[`DEAC_BIT_STANDBY];
            st_next.enable = wdata[`DEAC_BIT_ENABLE];
            if (!wdata[`DEAC_BIT_ROWMODE]) begin
                // Leaving row mode drops the latches unprogrammed
                st_next.row_mode = 1'b0;
                st_next.row_held = 1'b0;
                st_next.mask = 8'h00;
                st_next.latch = '0;
            end else if (!st_reg.row_mode) begin
                // Entering row mode clears every latch and forgets the row
                st_next.row_mode = 1'b1;
                st_next.row_held = 1'b0;
                st_next.mask = 8'h00;
                st_next.latch = '0;
            end
            // Start only with enable and an already entered row mode
            if (wdata[`DEAC_BIT_START] && wdata[`DEAC_BIT_ENABLE] && wdata[`DEAC_BIT_ROWMODE]
                && row_mode_now) begin
                st_next.row_start = 1'b1;
                st_next.tm_start = 1'b1;
                st_next.pgm = PGM_ROW;
            end
        end

        // Array window write; reserved control bits never reach any state
        if (wr_ok && hit_win && access_ok) begin
            if (st_reg.row_mode) begin
                // First write latches the row, others must stay in it
                if (!st_reg.row_held) begin
                    st_next.row_held = 1'b1;
                    st_next.row_page = page_num(st_reg.bank);
                    st_next.row_idx = idx[5:3];
                    st_next.latch[idx[2:0]] = wdata;
                    st_next.mask[idx[2:0]] = 1'b1;
                end else if (st_reg.row_idx == idx[5:3] && st_reg.row_page == page_num(st_reg.bank)) begin
                    st_next.latch[idx[2:0]] = wdata;
                    st_next.mask[idx[2:0]] = 1'b1;
                end
                // Writes to another row are dropped
            end else if (st_reg.enable) begin
                // Byte mode goes straight to the addressed byte
                st_next.row_page = page_num(st_reg.bank);
                st_next.row_idx = idx[5:3];
                st_next.latch = '0;
                st_next.latch[idx[2:0]] = wdata;
                st_next.mask = 8'h00;
                st_next.mask[idx[2:0]] = 1'b1;
                st_next.tm_start = 1'b1;
                st_next.pgm = PGM_BYTE;
            end
        end
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.wait_req <= 1'b1;
            st_reg.rdata <= `DEAC_NO_DATA;
            st_reg.standby <= 1'(`DEAC_CTRL_RESET >> `DEAC_BIT_STANDBY);
            st_reg.bank <= `DEAC_BANK_RESET;
            st_reg.pgm <= PGM_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus outputs straight from the state register
    assign avs_readdata = {24'h000000, st_reg.rdata};
    assign avs_waitrequest = st_reg.wait_req;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ctrl_frozen_busy: assert property (wr_ok && hit_ctrl && busy_now
        |=> $stable(st_reg.standby) && $stable(st_reg.enable) && $stable(st_reg.row_mode))
        else $error("control changed while busy");
    a_busy_read_only: assert property (accept && avs_read && hit_ctrl
        |=> st_reg.rdata[`DEAC_BIT_BUSY] == $past(busy_now) && st_reg.rdata[7:2] == 6'h00)
        else $error("control read shows more than busy");
    a_start_needs_enable: assert property (st_reg.tm_start |-> st_reg.enable)
        else $error("programming started without enable");
    a_row_start_guard: assert property (st_reg.row_start |-> st_reg.row_mode && st_reg.enable)
        else $error("start bit set outside enabled row mode");
    a_row_end_clear: assert property (nv.tm_done && st_reg.pgm == PGM_ROW
        |=> !st_reg.row_start && !st_reg.row_mode && st_reg.mask == 8'h00)
        else $error("row mode not cleared at end of cycle");
    a_standby_read_void: assert property (accept && avs_read && hit_win && st_reg.standby
        |=> avs_readdata == 32'h00000000)
        else $error("array answered in standby");
    a_busy_write_abort: assert property (wr_ok && hit_win && busy_now
        |=> !st_reg.tm_start && $stable(st_reg.mask))
        else $error("array write accepted while busy");
    a_latch_clear_entry: assert property (wr_ok && hit_ctrl && !busy_now && wdata[`DEAC_BIT_ROWMODE]
        && !st_reg.row_mode |=> st_reg.row_mode && st_reg.mask == 8'h00)
        else $error("row latches not cleared on mode entry");
    a_byte_program: assert property (wr_ok && hit_win && access_ok && !st_reg.row_mode && st_reg.enable
        |=> st_reg.tm_start && $onehot(st_reg.mask) ##1 nv.tm_busy)
        else $error("byte write did not start a single-byte cycle");
    a_bus_answer_once: assert property ((avs_read || avs_write) && st_reg.wait_req
        |=> !st_reg.wait_req ##1 st_reg.wait_req)
        else $error("bus answer not a single cycle");
    // No request, no answer
    a_idle_wait_high: assert property (!avs_read && !avs_write |=> st_reg.wait_req)
        else $error("answer given without a request");
    // Array reads during programming come back empty
    a_busy_read_void: assert property (accept && avs_read && hit_win && busy_now
        |=> avs_readdata == 32'h00000000)
        else $error("array answered while busy");
    // Array reads in row mode come back empty
    a_row_read_void: assert property (accept && avs_read && hit_win && st_reg.row_mode
        |=> avs_readdata == 32'h00000000)
        else $error("array answered in row mode");

    // ********************************************************
    // Checks on registers and row handling
    // ********************************************************
    // Bank select and byte mode
    a_bank_write_takes: assert property (wr_ok && hit_bank |=> st_reg.bank == $past(wdata))
        else $error("bank write not taken");
    // Byte writes without enable start nothing
    a_byte_needs_enable: assert property (wr_ok && hit_win && !st_reg.row_mode && !st_reg.enable
        |=> !st_reg.tm_start)
        else $error("byte write started a cycle without enable");
    // The first row write fixes the row
    a_row_first_latch: assert property (wr_ok && hit_win && access_ok && st_reg.row_mode
        && !st_reg.row_held |=> st_reg.row_held && st_reg.row_idx == $past(idx[5:3]))
        else $error("first row write did not latch the row");
    // Writes to another row leave the latches alone
    a_row_other_drop: assert property (wr_ok && hit_win && access_ok && st_reg.row_mode
        && st_reg.row_held && idx[5:3] != st_reg.row_idx && !nv.tm_done |=> $stable(st_reg.mask))
        else $error("write to another row was loaded");
    // Leaving row mode throws the loaded bytes away
    a_row_abandon: assert property (wr_ok && hit_ctrl && !busy_now && !wdata[`DEAC_BIT_ROWMODE]
        |=> !st_reg.row_mode && st_reg.mask == 8'h00)
        else $error("row latches kept after leaving row mode");
    // A start bit without enable and row mode is dropped
    a_start_refused: assert property (wr_ok && hit_ctrl && !busy_now && wdata[`DEAC_BIT_START]
        && !(wdata[`DEAC_BIT_ENABLE] && row_mode_now) |=> !st_reg.row_start && !st_reg.tm_start)
        else $error("refused start bit launched a cycle");
    // Array writes in standby change nothing
    a_standby_write_drop: assert property (wr_ok && hit_win && st_reg.standby && !nv.tm_done
        |=> !st_reg.tm_start && $stable(st_reg.mask))
        else $error("array write taken in standby");

    // Scenario covers

    c_byte_cycle: cover property (st_reg.tm_start && st_reg.pgm == PGM_BYTE);
    c_row_cycle: cover property (nv.tm_done && st_reg.pgm == PGM_ROW && st_reg.mask != 8'h00);
    c_row_abandon: cover property (wr_ok && hit_ctrl && !busy_now && st_reg.row_mode && st_reg.mask != 8'h00
        && !wdata[`DEAC_BIT_ROWMODE]);
    c_standby_read: cover property (accept && avs_read && hit_win && st_reg.standby);
    c_busy_ctrl_refused: cover property (wr_ok && hit_ctrl && busy_now);
endmodule
